/* File: cce_pkg.sv */
// Notes on behaviour
// RULE1 - complement writes inverted file, only zero flag
// RULE2 - destination bit 0 to working, 1 to file
// RULE3 - decrement opcode 0000011d, subtracts one from file
// RULE4 - decrement updates overflow, carry, half carry, zero
// RULE5 - equal compare skips on match, flags untouched
// RULE6 - equal compare opcode upper byte 00110001
// RULE7 - greater compare 00110010 skips when file greater
// RULE8 - less compare 00110000 skips when file less
// RULE9 - skip discards next instruction, runs no-operation
// RULE10 - compares decode, read, process, never write
// RULE11 - low nibble plus six if above nine or half carry
// RULE12 - high nibble plus six, seven when low overflows
// RULE13 - store bit 0 file and working, 1 file only
// RULE14 - decimal adjust yields packed bcd, only carry changes
// RULE15 - decrement skip zero: no flags, skip on zero
package cce_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned ADDR_W = 8;
  // upper-byte opcodes; for d/s forms the low bit is masked off
  localparam logic [7:0] OP_COMPLEMENT = 8'h12;
  localparam logic [7:0] OP_DECREMENT = 8'h06;
  localparam logic [7:0] OP_DEC_SKIP_ZERO = 8'h16;
  localparam logic [7:0] OP_DECIMAL_ADJUST = 8'h2e;
  localparam logic [7:0] OP_CMP_EQUAL = 8'h31;
  localparam logic [7:0] OP_CMP_GREATER = 8'h32;
  localparam logic [7:0] OP_CMP_LESS = 8'h30;
  localparam logic [7:0] OP_MASK_SEL = 8'hfe;
  localparam int unsigned SEL_BIT = 8;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_ADJ = 4'h6;
  localparam logic [3:0] BCD_ADJ_HI = 4'h7;
  localparam logic [7:0] DATA_ONE = 8'h01;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  // no-operation phases after a skip, counted down to zero
  localparam logic [2:0] NOP_LAST = 3'h3;

  typedef enum logic [2:0] {
    CCE_OP_NONE,
    CCE_OP_COMP,
    CCE_OP_DEC,
    CCE_OP_DSZ,
    CCE_OP_DAW,
    CCE_OP_CEQ,
    CCE_OP_CGT,
    CCE_OP_CLT
  } cce_op_t;

  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
  } cce_flags_t;

  typedef struct packed {
    logic [7:0] file_data;
    logic write_file;
    logic write_working;
    logic skip;
    cce_flags_t flags;
    cce_flags_t flag_we;
  } cce_result_t;
endpackage

/* File: cce_alu.sv */
`timescale 1ns/10ps
`default_nettype none
// combinational datapath for the decoded operation
module cce_alu (
  input wire cce_pkg::cce_op_t op,
  input wire logic sel,
  input wire logic [7:0] file_val,
  input wire logic [7:0] work_val,
  input wire cce_pkg::cce_flags_t flags_in,
  output cce_pkg::cce_result_t res
);
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic [3:0] lo_nib;
  logic [3:0] hi_nib;
  logic lo_big;
  logic hi_big;
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;

  // shared decrement arithmetic, carry means no borrow
  assign diff = {1'b0, file_val} - {1'b0, cce_pkg::DATA_ONE};
  assign low_diff = {1'b0, file_val[3:0]} - 5'h01;
  assign lo_nib = work_val[3:0];
  assign hi_nib = work_val[7:4];
  assign lo_big = lo_nib > cce_pkg::BCD_LIMIT;
  assign hi_big = hi_nib > cce_pkg::BCD_LIMIT;

  // bcd nibble corrections
  always_comb begin
    lo_sum = {1'b0, lo_nib};
    hi_sum = {1'b0, hi_nib};
    // RULE11 low nibble correction
    if (lo_big || flags_in.half_carry_flag) begin
      lo_sum = {1'b0, lo_nib} + {1'b0, cce_pkg::BCD_ADJ};
    end
    // RULE12 high nibble correction
    if ((hi_big || flags_in.carry_flag) && lo_big) begin
      hi_sum = {1'b0, hi_nib} + {1'b0, cce_pkg::BCD_ADJ_HI};
    end else if (hi_big || flags_in.carry_flag) begin
      hi_sum = {1'b0, hi_nib} + {1'b0, cce_pkg::BCD_ADJ};
    end
  end

  // result selection per operation
  always_comb begin
    res = '0;
    case (op)
      cce_pkg::CCE_OP_COMP: begin
        // RULE1 inverse, zero only
        res.file_data = ~file_val;
        res.flags.zero_flag = (~file_val) == cce_pkg::DATA_ZERO;
        res.flag_we.zero_flag = 1'b1;
        // RULE2 destination routing
        res.write_file = sel;
        res.write_working = ~sel;
      end
      cce_pkg::CCE_OP_DEC: begin
        // RULE3 subtract one
        res.file_data = diff[7:0];
        res.write_file = sel;
        res.write_working = ~sel;
        // RULE4 all four arithmetic flags
        res.flags.carry_flag = ~diff[8];
        res.flags.half_carry_flag = ~low_diff[4];
        res.flags.zero_flag = diff[7:0] == cce_pkg::DATA_ZERO;
        res.flags.overflow_flag = file_val[7] & ~diff[7];
        res.flag_we = '1;
      end
      cce_pkg::CCE_OP_DSZ: begin
        // RULE15 no flags, skip on zero
        res.file_data = diff[7:0];
        res.write_file = sel;
        res.write_working = ~sel;
        res.skip = diff[7:0] == cce_pkg::DATA_ZERO;
      end
      cce_pkg::CCE_OP_DAW: begin
        // RULE14 packed bcd result, carry only
        res.file_data = {hi_sum[3:0], lo_sum[3:0]};
        res.flags.carry_flag = hi_sum[4] | flags_in.carry_flag;
        res.flag_we.carry_flag = 1'b1;
        // RULE13 file always, working when bit clear
        res.write_file = 1'b1;
        res.write_working = ~sel;
      end
      // RULE5 equal compare, no flags
      cce_pkg::CCE_OP_CEQ: res.skip = file_val == work_val;
      // RULE7 unsigned greater
      cce_pkg::CCE_OP_CGT: res.skip = file_val > work_val;
      // RULE8 unsigned less
      cce_pkg::CCE_OP_CLT: res.skip = file_val < work_val;
      default: res = '0;
    endcase
  end
endmodule
`default_nettype wire

/* File: cce_exec.sv */
`timescale 1ns/10ps
`default_nettype none
// four-phase executor; file memory read and written locally
module cce_exec #(
  parameter int unsigned FILE_DEPTH = 256
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic file_load,
  input wire logic [7:0] file_load_addr,
  input wire logic [7:0] file_load_data,
  output logic instr_ready,
  output logic [7:0] working_register,
  output cce_pkg::cce_flags_t status_flags,
  output logic skip_active,
  output logic instr_done,
  output logic illegal_instr
);
  // refuse a depth that the 8-bit file address cannot serve
  if (FILE_DEPTH < 1 || FILE_DEPTH > (1 << cce_pkg::ADDR_W)) begin
    $error("file depth must be 1 to 256");
  end

  typedef enum logic [2:0] {
    CCE_IDLE,
    CCE_DECODE,
    CCE_READ,
    CCE_PROCESS,
    CCE_WRITE,
    CCE_NOP
  } cce_phase_t;

  logic [7:0] file_mem [FILE_DEPTH];
  cce_phase_t phase_q;
  cce_phase_t phase_d;
  logic [15:0] instr_q;
  cce_pkg::cce_op_t op_q;
  logic [7:0] file_val_q;
  cce_pkg::cce_result_t res;
  cce_pkg::cce_result_t res_q;
  logic [2:0] nop_left_q;
  logic [7:0] addr;

  // match the upper byte, masking the select bit where present
  function automatic cce_pkg::cce_op_t decode_op(input logic [7:0] hi);
    cce_pkg::cce_op_t o;
    o = cce_pkg::CCE_OP_NONE;
    // RULE6 equal compare opcode
    if (hi == cce_pkg::OP_CMP_EQUAL) begin
      o = cce_pkg::CCE_OP_CEQ;
    end else if (hi == cce_pkg::OP_CMP_GREATER) begin
      o = cce_pkg::CCE_OP_CGT;
    end else if (hi == cce_pkg::OP_CMP_LESS) begin
      o = cce_pkg::CCE_OP_CLT;
    end else if ((hi & cce_pkg::OP_MASK_SEL) == cce_pkg::OP_COMPLEMENT) begin
      o = cce_pkg::CCE_OP_COMP;
    // RULE3 decrement opcode match
    end else if ((hi & cce_pkg::OP_MASK_SEL) == cce_pkg::OP_DECREMENT) begin
      o = cce_pkg::CCE_OP_DEC;
    end else if ((hi & cce_pkg::OP_MASK_SEL) ==
                 cce_pkg::OP_DEC_SKIP_ZERO) begin
      o = cce_pkg::CCE_OP_DSZ;
    end else if ((hi & cce_pkg::OP_MASK_SEL) ==
                 cce_pkg::OP_DECIMAL_ADJUST) begin
      o = cce_pkg::CCE_OP_DAW;
    end
    return o;
  endfunction

  assign addr = instr_q[7:0];

  cce_alu u_alu (
    .op(op_q),
    .sel(instr_q[cce_pkg::SEL_BIT]),
    .file_val(file_val_q),
    .work_val(working_register),
    .flags_in(status_flags),
    .res(res)
  );

  // phase sequencing
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      CCE_IDLE: begin
        // ready is low for one edge after reset: offers are refused
        if (instr_valid && instr_ready) begin
          phase_d = CCE_DECODE;
        end
      end
      CCE_DECODE: phase_d = CCE_READ;
      CCE_READ: phase_d = CCE_PROCESS;
      CCE_PROCESS: phase_d = CCE_WRITE;
      CCE_WRITE: begin
        // RULE9 skip costs four extra cycles
        if (res_q.skip) begin
          phase_d = CCE_NOP;
        end else begin
          phase_d = CCE_IDLE;
        end
      end
      CCE_NOP: begin
        if (nop_left_q == 3'h0) begin
          phase_d = CCE_IDLE;
        end
      end
      default: phase_d = CCE_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q <= CCE_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // instruction capture and decode
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      instr_q <= '0;
      op_q <= cce_pkg::CCE_OP_NONE;
    end else if (phase_q == CCE_IDLE && instr_valid && instr_ready) begin
      instr_q <= instr_word;
    end else if (phase_q == CCE_DECODE) begin
      op_q <= decode_op(instr_q[15:8]);
    end
  end

  // RULE10 read in second phase, process in third
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      file_val_q <= '0;
      res_q <= '0;
    end else if (phase_q == CCE_READ) begin
      file_val_q <= file_mem[addr];
    end else if (phase_q == CCE_PROCESS) begin
      res_q <= res;
    end
  end

  // file memory: external preload or fourth-phase write back
  always_ff @(posedge clk_sys) begin
    if (phase_q == CCE_WRITE && res_q.write_file) begin
      file_mem[addr] <= res_q.file_data;
    end else if (file_load && phase_q == CCE_IDLE) begin
      file_mem[file_load_addr] <= file_load_data;
    end
  end

  // RULE2 working register written only when routed there
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      working_register <= '0;
    end else if (phase_q == CCE_WRITE && res_q.write_working) begin
      working_register <= res_q.file_data;
    end
  end

  // per-bit flag update; compares carry no enables
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      status_flags <= '0;
    end else if (phase_q == CCE_WRITE) begin
      status_flags <= (res_q.flags & res_q.flag_we) |
                      (status_flags & ~res_q.flag_we);
    end
  end

  // RULE9 four no-operation cycles stand in for the discarded fetch
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      skip_active <= 1'b0;
      nop_left_q <= '0;
    end else if (phase_q == CCE_WRITE && res_q.skip) begin
      skip_active <= 1'b1;
      nop_left_q <= cce_pkg::NOP_LAST;
    end else if (phase_q == CCE_NOP && nop_left_q != 3'h0) begin
      nop_left_q <= nop_left_q - 3'h1;
    end else begin
      skip_active <= 1'b0;
    end
  end

  // handshake and completion status
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      instr_ready <= 1'b0;
      instr_done <= 1'b0;
      illegal_instr <= 1'b0;
    end else begin
      instr_ready <= (phase_d == CCE_IDLE);
      instr_done <= (phase_q != CCE_IDLE) && (phase_d == CCE_IDLE);
      if (phase_q == CCE_READ) begin
        illegal_instr <= op_q == cce_pkg::CCE_OP_NONE;
      end
    end
  end
endmodule
`default_nettype wire

/* File: cce_exec_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module cce_exec_monitor (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic instr_ready,
  input wire logic [7:0] working_register,
  input wire cce_pkg::cce_flags_t status_flags,
  input wire logic skip_active,
  input wire logic instr_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // accepted opcode byte; d/s select bit kept for the routing checks
  wire logic take = instr_valid && instr_ready;
  wire logic [7:0] opc = instr_word[15:8];
  wire logic [7:0] opm = instr_word[15:8] & 8'hfe;

  exec_time_a: assert property (take |-> ##[5:9] instr_done)
    else $error("instruction did not complete in time");
  skip_len_a: assert property ($rose(skip_active) |->
    skip_active [*4] ##1 (!skip_active && instr_done))
    else $error("skip no-op length wrong");
  cmp_quiet_a: assert property (take && opc inside {8'h30, 8'h31, 8'h32} |=>
    $stable({status_flags, working_register}) [*8])
    else $error("compare changed flags or working value");
  dsz_flags_a: assert property (take && opm == 8'h16 |=>
    $stable(status_flags) [*8])
    else $error("decrement skip changed flags");
  comp_flags_a: assert property (take && opm == 8'h12 |=>
    $stable({status_flags.overflow_flag, status_flags.half_carry_flag,
      status_flags.carry_flag}) [*8])
    else $error("complement touched a flag other than zero");
  daw_flags_a: assert property (take && opm == 8'h2e |=>
    $stable({status_flags.overflow_flag, status_flags.zero_flag,
      status_flags.half_carry_flag}) [*8])
    else $error("decimal adjust touched a flag other than carry");
  to_file_a: assert property (take && opc inside {8'h13, 8'h07, 8'h17} |=>
    $stable(working_register) [*8])
    else $error("file destination wrote the working value");
  daw_file_a: assert property (take && opc == 8'h2f |=>
    $stable(working_register) [*8])
    else $error("file-only adjust wrote the working value");
endmodule
`default_nettype wire

/* File: cce_exec_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module cce_exec_tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic file_load = 1'b0;
  logic [7:0] file_load_addr = 8'h00;
  logic [7:0] file_load_data = 8'h00;
  logic instr_ready, skip_active, instr_done, illegal_instr;
  logic [7:0] working_register;
  cce_pkg::cce_flags_t status_flags, fl;
  int error_cnt = 0;
  int total_checks = 0;

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  cce_exec u_cce_exec (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .file_load(file_load), .file_load_addr(file_load_addr),
    .file_load_data(file_load_data), .instr_ready(instr_ready),
    .working_register(working_register), .status_flags(status_flags),
    .skip_active(skip_active), .instr_done(instr_done),
    .illegal_instr(illegal_instr));

  task end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // preload one file location while the core is idle
  task load(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    file_load = 1'b1;
    file_load_addr = a;
    file_load_data = d;
    @(negedge clk_sys);
    file_load = 1'b0;
  endtask

  // offer one instruction and count edges from take to completion
  task exec(input logic [7:0] op, input logic [7:0] a, input logic skp);
    int n;
    n = 0;
    @(negedge clk_sys);
    instr_word = {op, a};
    instr_valid = 1'b1;
    while (instr_ready !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 50) begin
      error_cnt++;
      $display("unexpected at %0t: core never ready", $time);
      end_sim();
    end
    @(posedge clk_sys);
    @(negedge clk_sys);
    instr_valid = 1'b0;
    n = 1;
    while (instr_done !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 40) begin
      error_cnt++;
      $display("unexpected at %0t: instruction never done", $time);
      end_sim();
    end
    chk(8'(n), skp ? 8'h09 : 8'h05);
  endtask

  // read a file location by complementing it into the working value
  task rd(input logic [7:0] a, input logic [7:0] exp);
    exec(cce_pkg::OP_COMPLEMENT, a, 1'b0);
    chk(working_register, ~exp);
  endtask

  // working value with carry and half carry both equal to c
  task set_w(input logic [7:0] v, input logic c);
    load(8'hf0, {7'h00, c});
    exec(cce_pkg::OP_DECREMENT, 8'hf0, 1'b0);
    load(8'hf1, ~v);
    exec(cce_pkg::OP_COMPLEMENT, 8'hf1, 1'b0);
  endtask

  task t_comp();
    load(8'h01, 8'h13);
    rd(8'h01, 8'h13);
    load(8'h02, 8'hff);
    exec(cce_pkg::OP_COMPLEMENT | 8'h01, 8'h02, 1'b0);
    chk(working_register, 8'hec);
    chk({7'h00, status_flags.zero_flag}, 8'h01);
    rd(8'h02, 8'h00);
  endtask

  task t_dec();
    load(8'h03, 8'h01);
    exec(cce_pkg::OP_DECREMENT | 8'h01, 8'h03, 1'b0);
    chk({4'h0, status_flags}, 8'h07);
    rd(8'h03, 8'h00);
    load(8'h04, 8'h80);
    exec(cce_pkg::OP_DECREMENT, 8'h04, 1'b0);
    chk(working_register, 8'h7f);
    chk({4'h0, status_flags}, 8'h09);
    load(8'h05, 8'h00);
    exec(cce_pkg::OP_DECREMENT, 8'h05, 1'b0);
    chk({4'h0, status_flags}, 8'h00);
  endtask

  // every compare against below, equal and above the working value
  task t_cmp();
    logic [7:0] ops [3];
    logic [7:0] v;
    logic s;
    ops = '{cce_pkg::OP_CMP_LESS, cce_pkg::OP_CMP_EQUAL,
      cce_pkg::OP_CMP_GREATER};
    set_w(8'h50, 1'b1);
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 3; j++) begin
        v = 8'h4f + 8'(j);
        load(8'h10, v);
        fl = status_flags;
        s = (i == 0) ? (v < 8'h50) : (i == 1) ? (v == 8'h50) : (v > 8'h50);
        exec(ops[i], 8'h10, s);
        chk({4'h0, status_flags}, {4'h0, fl});
        chk(working_register, 8'h50);
      end
    end
  endtask

  task decimal_adjust(input logic [7:0] v, input logic c, input logic s,
    input logic [7:0] r, input logic cy);
    set_w(v, c);
    exec(cce_pkg::OP_DECIMAL_ADJUST | {7'h00, s}, 8'h20, 1'b0);
    chk({7'h00, status_flags.carry_flag}, {7'h00, cy});
    chk(working_register, s ? v : r);
    rd(8'h20, r);
  endtask

  task t_daw();
    decimal_adjust(8'ha5, 1'b0, 1'b0, 8'h05, 1'b1);
    decimal_adjust(8'haa, 1'b0, 1'b1, 8'h10, 1'b1);
    decimal_adjust(8'h9a, 1'b0, 1'b0, 8'h90, 1'b0);
    decimal_adjust(8'h12, 1'b1, 1'b0, 8'h78, 1'b1);
    decimal_adjust(8'h45, 1'b0, 1'b0, 8'h45, 1'b0);
  endtask

  task t_dsz();
    load(8'h40, 8'h02);
    fl = status_flags;
    exec(cce_pkg::OP_DEC_SKIP_ZERO | 8'h01, 8'h40, 1'b0);
    exec(cce_pkg::OP_DEC_SKIP_ZERO | 8'h01, 8'h40, 1'b1);
    chk({4'h0, status_flags}, {4'h0, fl});
    rd(8'h40, 8'h00);
    load(8'h41, 8'h01);
    exec(cce_pkg::OP_DEC_SKIP_ZERO, 8'h41, 1'b1);
    chk(working_register, 8'h00);
  endtask

  // undecoded byte beside the compare codes: nothing written, flagged
  task t_bad();
    logic [7:0] w;
    load(8'h50, 8'h3c);
    w = working_register;
    fl = status_flags;
    exec(8'h33, 8'h50, 1'b0);
    chk({7'h00, illegal_instr}, 8'h01);
    chk({4'h0, status_flags}, {4'h0, fl});
    chk(working_register, w);
    rd(8'h50, 8'h3c);
    chk({7'h00, illegal_instr}, 8'h00);
  endtask

  // reset for 20 cycles, then each scenario in turn
  initial begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    t_comp();
    t_dec();
    t_cmp();
    t_daw();
    t_dsz();
    t_bad();
    end_sim();
  end
endmodule

bind cce_exec cce_exec_monitor u_cce_exec_monitor (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_ready(instr_ready), .working_register(working_register),
  .status_flags(status_flags), .skip_active(skip_active),
  .instr_done(instr_done));
`default_nettype wire
